// File: hdl/prs_cfg.svh
// constants of the page request stop marker link: widths, offsets, codes
// assumes inclusion by bare name from the package and the modules
`ifndef PRS_CFG_SVH
`define PRS_CFG_SVH

// ==========================================================
// field widths
`define PRS_PASID_W      20
`define PRS_IDX_W        9
`define PRS_NIDX         512
`define PRS_ADDR_W       52
`define PRS_CNT_W        10
`define PRS_CODE_W       4

// ==========================================================
// message encodings
`define PRS_MARKER_TYPE  5'h00
`define PRS_TC_ZERO      3'h0
`define PRS_RSP_SUCCESS  4'h0
`define PRS_RSP_INVALID  4'h1
`define PRS_RSP_FAILURE  4'hF

// ==========================================================
// register byte offsets
`define PRS_OFS_CAP      8'h00
`define PRS_OFS_CTRL     8'h04
`define PRS_OFS_STATUS   8'h08
`define PRS_OFS_ALLOC    8'h0C
`define PRS_OFS_CFG      8'h10

// ==========================================================
// register fields and fixed values
`define PRS_CAP_QDEPTH   5'h00
`define PRS_CAP_ALIGNED  1'h1
`define PRS_CAP_GLOBAL   1'h0
`define PRS_CTRL_EN_BIT  15
`define PRS_STAT_RSP_BIT 15
`define PRS_RSP_PASID_REQ 1'h1
`define PRS_CFG_PFX_BIT  0
`define PRS_CFG_IDO_BIT  1
`define PRS_CFG_RST_BIT  2
`define PRS_CFG_BUSY_BIT 8
`define PRS_CFG_CNT_LSB  16

`endif

// File: hdl/prs_pkg.sv
// types shared by both ends of the page request link
// assumes prs_cfg.svh on the include path
package prs_pkg;
  `include "prs_cfg.svh"

  // ==========================================================
  // device to host message
  typedef struct packed {
    logic                     prefix;
    logic [`PRS_PASID_W-1:0]  pasid;
    logic                     exe;
    logic                     priv;
    logic                     last;
    logic                     wr;
    logic                     rd;
    logic [4:0]               mtype;
    logic [`PRS_IDX_W-1:0]    index;
    logic [`PRS_ADDR_W-1:0]   addr;
    logic [2:0]               tc;
    logic                     ro;
    logic                     ido;
  } prs_msg_s;

  // ==========================================================
  // host to device group response
  typedef struct packed {
    logic                     prefix;
    logic [`PRS_PASID_W-1:0]  pasid;
    logic [`PRS_IDX_W-1:0]    index;
    logic [`PRS_CODE_W-1:0]   code;
  } prs_rsp_s;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_DRAIN = 4'h2,
    ST_MARK  = 4'h4,
    ST_SEND  = 4'h8
  } prs_stop_e;
endpackage

// File: hdl/prs_link_if.sv
// link between the function and the host translation agent
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface prs_link_if
  import prs_pkg::*;
();
  logic      msg_valid;
  logic      msg_ready;
  prs_msg_s  msg;
  logic      rsp_valid;
  prs_rsp_s  rsp;
  logic      rsp_pasid_req;
  logic      prefix_en;
  logic      pri_reset;

  modport dev (
    output msg_valid, msg, rsp_pasid_req, prefix_en, pri_reset,
    input  msg_ready, rsp_valid, rsp
  );
  modport host (
    input  msg_valid, msg, rsp_pasid_req, prefix_en, pri_reset,
    output msg_ready, rsp_valid, rsp
  );
endinterface

// File: hdl/prs_msg_fmt.sv
// builds one outgoing message from request fields or as a stop marker
// assumes the caller registers the result
`timescale 1ns/1ps
`include "prs_cfg.svh"
module prs_msg_fmt
  import prs_pkg::*;
(
  input  wire logic                     is_marker,
  input  wire logic                     prefix,
  input  wire logic [`PRS_PASID_W-1:0]  pasid,
  input  wire logic                     exe,
  input  wire logic                     priv,
  input  wire logic                     last,
  input  wire logic                     rd,
  input  wire logic                     wr,
  input  wire logic [`PRS_IDX_W-1:0]    index,
  input  wire logic [`PRS_ADDR_W-1:0]   addr,
  input  wire logic                     ido_en,
  output prs_msg_s                      msg
);
  always_comb
  begin
    msg        = '0;
    msg.pasid  = pasid;
    // (R9) class zero, no relaxed order
    msg.tc     = `PRS_TC_ZERO;
    msg.ro     = 1'b0;
    msg.ido    = ido_en;
    msg.mtype  = `PRS_MARKER_TYPE;
    if (is_marker)
    begin
      // (R5) prefixed, last set, no access
      msg.prefix = 1'b1;
      msg.last   = 1'b1;
      msg.rd     = 1'b0;
      msg.wr     = 1'b0;
      // (R6) address and index zeroed
      msg.addr   = '0;
      msg.index  = '0;
      // (R8) prefix request bits zero
      msg.exe    = 1'b0;
      msg.priv   = 1'b0;
      // (R7) marker type code
      msg.mtype  = `PRS_MARKER_TYPE;
    end
    else
    begin
      msg.prefix = prefix;
      msg.exe    = exe;
      msg.priv   = priv;
      msg.last   = last;
      msg.rd     = rd;
      msg.wr     = wr;
      msg.index  = index;
      // (R18) address passed through unchanged; page alignment is not enforced here
      msg.addr   = addr;
    end
  end
endmodule

// File: hdl/prs_device.sv
// function end: page requests, stop marker sequence, response matching
// assumes the host answers each last-flagged request once
`timescale 1ns/1ps
`include "prs_cfg.svh"

// Functional notes
// (R1) marker only after pending requests sent
// (R2) marker never overtakes earlier requests
// (R3) host treats later same ID as new
// (R4) marker unanswered, unindexed, uncounted
// (R5) marker prefixed, last set, no access
// (R6) marker address and index reserved
// (R7) marker type field is zero
// (R8) marker prefix request bits reserved
// (R9) marker class zero, relaxed order clear
// (R10) marker only for stopping ID, closed groups
// (R11) host fails bad address or no access
// (R12) host fails disabled, bad ID, exec-without-read
// (R13) host unspecified failure is terminal until reset
// (R14) no response prefix while enable clear; host prefixes responses without checking prefix_en
// (R15) response prefix mirrors request prefix
// (R16) response prefix copies ID, reserves bits
// (R17) queue depth field, zero means 32
// (R18) capability bit 5 page aligned
// (R19) capability bit 6 global invalidate
// (R20) smallest translation unit field, reset zero
// (R21) cache enable bit locks prefix enables
// (R22) status bit 15 expects prefixed responses
// (R23) stop: drain group, mark stale, send
// (R24) marker shares request transmit queue
module prs_device
  import prs_pkg::*;
(
  input  wire logic                     mclk,
  input  wire logic                     reset,
  prs_link_if.dev                       link,
  input  wire logic [7:0]               reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_we,
  input  wire logic                     reg_re,
  output logic      [31:0]              reg_rdata,
  input  wire logic                     req_valid,
  output logic                          req_ready,
  input  wire logic                     req_prefix,
  input  wire logic [`PRS_PASID_W-1:0]  req_pasid,
  input  wire logic                     req_exe,
  input  wire logic                     req_priv,
  input  wire logic                     req_rd,
  input  wire logic                     req_wr,
  input  wire logic                     req_last,
  input  wire logic [`PRS_IDX_W-1:0]    req_index,
  input  wire logic [`PRS_ADDR_W-1:0]   req_addr,
  input  wire logic                     stop_valid,
  output logic                          stop_ready,
  input  wire logic [`PRS_PASID_W-1:0]  stop_pasid,
  output logic                          stop_done,
  output logic                          rsp_valid,
  output prs_rsp_s                      rsp
);
  typedef struct packed {
    prs_stop_e                              st;
    logic [`PRS_PASID_W-1:0]                stop_pasid;
    logic [4:0]                             smallest_translation_unit;
    logic                                   ats_en;
    logic                                   prefix_en;
    logic                                   ido_en;
    logic [31:0]                            alloc;
    logic [`PRS_CNT_W-1:0]                  out_cnt;
    logic                                   grp_open;
    logic [`PRS_PASID_W-1:0]                grp_pasid;
    logic [`PRS_IDX_W-1:0]                  grp_index;
    logic                                   o_vld;
    logic                                   o_mark;
    prs_msg_s                               o_msg;
    logic [31:0]                            rdata;
    logic                                   stop_done;
    logic                                   rsp_vld;
    prs_rsp_s                               rsp;
    logic                                   pri_rst;
    logic [`PRS_NIDX-1:0]                   out_vld;
    logic [`PRS_NIDX-1:0]                   out_pfx;
    logic [`PRS_NIDX-1:0]                   stale;
    logic [`PRS_NIDX-1:0][`PRS_PASID_W-1:0] out_pasid;
  } prs_dev_s;

  prs_dev_s  s;
  prs_dev_s  next_s;
  prs_msg_s  req_msg;
  prs_msg_s  mark_msg;
  logic      out_free;
  logic      blocked;
  logic      credit_ok;
  logic      accept;
  logic      inc;
  logic      dec;

  // ==========================================================
  // message formatting
  prs_msg_fmt u_req_fmt (
    .is_marker (1'b0),
    .prefix    (req_prefix),
    .pasid     (req_pasid),
    .exe       (req_exe),
    .priv      (req_priv),
    .last      (req_last),
    .rd        (req_rd),
    .wr        (req_wr),
    .index     (req_index),
    .addr      (req_addr),
    .ido_en    (s.ido_en),
    .msg       (req_msg)
  );

  prs_msg_fmt u_mark_fmt (
    .is_marker (1'b1),
    .prefix    (1'b1),
    .pasid     (s.stop_pasid),
    .exe       (1'b0),
    .priv      (1'b0),
    .last      (1'b1),
    .rd        (1'b0),
    .wr        (1'b0),
    .index     ('0),
    .addr      ('0),
    .ido_en    (s.ido_en),
    .msg       (mark_msg)
  );

  // ==========================================================
  // request admission
  always_comb
  begin
    out_free  = !s.o_vld || link.msg_ready;
    // (R23) no new requests for a stopping ID unless finishing its group
    blocked   = (s.st != ST_IDLE) && req_prefix
                && (req_pasid == s.stop_pasid)
                && !(s.grp_open && (s.grp_pasid == req_pasid)
                     && (s.grp_index == req_index));
    // (R4) only page request groups count against the allocation
    credit_ok = (32'(s.out_cnt) < s.alloc);
    // (R24) the marker owns the single transmit slot while sending
    req_ready = out_free && !blocked && credit_ok && (s.st != ST_SEND);
    accept    = req_valid && req_ready;
  end

  // ==========================================================
  // next state
  always_comb
  begin
    next_s           = s;
    next_s.stop_done = 1'b0;
    next_s.rsp_vld   = 1'b0;
    next_s.pri_rst   = 1'b0;
    next_s.rdata     = '0;
    inc              = 1'b0;
    dec              = 1'b0;

    if (s.o_vld && link.msg_ready)
    begin
      next_s.o_vld = 1'b0;
      if (s.o_mark)
      begin
        // (R1) stop reported once the marker leaves
        next_s.o_mark    = 1'b0;
        next_s.stop_done = 1'b1;
        next_s.st        = ST_IDLE;
      end
    end

    // responses: stale ones only return credit and index
    if (link.rsp_valid && s.out_vld[link.rsp.index])
    begin
      next_s.out_vld[link.rsp.index] = 1'b0;
      next_s.stale[link.rsp.index]   = 1'b0;
      dec                            = 1'b1;
      // (R15) deliver with prefix and ID for matching
      if (!s.stale[link.rsp.index])
      begin
        next_s.rsp_vld = 1'b1;
        next_s.rsp     = link.rsp;
      end
    end

    if (accept)
    begin
      next_s.o_vld  = 1'b1;
      next_s.o_mark = 1'b0;
      next_s.o_msg  = req_msg;
      if (req_prefix)
      begin
        next_s.grp_open  = !req_last;
        next_s.grp_pasid = req_pasid;
        next_s.grp_index = req_index;
      end
      if (req_last)
      begin
        next_s.out_vld[req_index]   = 1'b1;
        next_s.out_pfx[req_index]   = req_prefix;
        next_s.stale[req_index]     = 1'b0;
        next_s.out_pasid[req_index] = req_pasid;
        inc                         = 1'b1;
      end
    end
    next_s.out_cnt = s.out_cnt + `PRS_CNT_W'(inc) - `PRS_CNT_W'(dec);

    // (R23) stop sequence
    unique case (s.st)
      ST_IDLE:
      begin
        if (stop_valid)
        begin
          next_s.stop_pasid = stop_pasid;
          next_s.st         = ST_DRAIN;
        end
      end
      ST_DRAIN:
      begin
        // (R10) wait until the group carries its last flag
        if (!(s.grp_open && (s.grp_pasid == s.stop_pasid)))
          next_s.st = ST_MARK;
      end
      ST_MARK:
      begin
        for (int i = 0; i < `PRS_NIDX; i++)
        begin
          if (s.out_vld[i] && s.out_pfx[i]
              && (s.out_pasid[i] == s.stop_pasid))
            next_s.stale[i] = 1'b1;
        end
        next_s.st = ST_SEND;
      end
      ST_SEND:
      begin
        // (R2) marker queued behind every earlier request
        if (!(s.o_vld && s.o_mark) && out_free)
        begin
          next_s.o_vld  = 1'b1;
          next_s.o_mark = 1'b1;
          next_s.o_msg  = mark_msg;
        end
      end
    endcase

    // register writes
    if (reg_we)
    begin
      unique case (reg_addr)
        `PRS_OFS_CTRL:
        begin
          // (R20) smallest translation unit
          next_s.smallest_translation_unit    = reg_wdata[4:0];
          next_s.ats_en = reg_wdata[`PRS_CTRL_EN_BIT];
        end
        `PRS_OFS_ALLOC:
          next_s.alloc = reg_wdata;
        `PRS_OFS_CFG:
        begin
          // (R21) prefix enables frozen while caching enabled
          if (!s.ats_en)
          begin
            next_s.prefix_en = reg_wdata[`PRS_CFG_PFX_BIT];
            next_s.ido_en    = reg_wdata[`PRS_CFG_IDO_BIT];
          end
          next_s.pri_rst = reg_wdata[`PRS_CFG_RST_BIT];
        end
        default:
        begin
        end
      endcase
    end

    // register reads, data valid the cycle after the strobe
    if (reg_re)
    begin
      unique case (reg_addr)
        // (R17) (R18) (R19) fixed capability fields
        `PRS_OFS_CAP:
          next_s.rdata = {25'h0, `PRS_CAP_GLOBAL, `PRS_CAP_ALIGNED,
                          `PRS_CAP_QDEPTH};
        `PRS_OFS_CTRL:
          next_s.rdata = {16'h0, s.ats_en, 10'h0, s.smallest_translation_unit};
        // (R22) prefixed responses expected
        `PRS_OFS_STATUS:
          next_s.rdata = {16'h0, `PRS_RSP_PASID_REQ, 15'h0};
        `PRS_OFS_ALLOC:
          next_s.rdata = s.alloc;
        `PRS_OFS_CFG:
          next_s.rdata = {6'h0, s.out_cnt, 7'h0, (s.st != ST_IDLE),
                          6'h0, s.ido_en, s.prefix_en};
        default:
          next_s.rdata = '0;
      endcase
    end

    // interface reset drops all tracking; the host may then answer again
    if (s.pri_rst)
    begin
      next_s.out_vld  = '0;
      next_s.stale    = '0;
      next_s.out_cnt  = '0;
      next_s.grp_open = 1'b0;
      next_s.o_vld    = 1'b0;
      next_s.o_mark   = 1'b0;
      next_s.st       = ST_IDLE;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      s    <= '0;
      s.st <= ST_IDLE;
    end
    else
      s <= next_s;
  end

  // ==========================================================
  // outputs
  assign link.msg_valid     = s.o_vld;
  assign link.msg           = s.o_msg;
  assign link.rsp_pasid_req = `PRS_RSP_PASID_REQ;
  assign link.prefix_en     = s.prefix_en;
  assign link.pri_reset     = s.pri_rst;
  assign reg_rdata          = s.rdata;
  assign stop_ready         = (s.st == ST_IDLE);
  assign stop_done          = s.stop_done;
  assign rsp_valid          = s.rsp_vld;
  assign rsp                = s.rsp;
endmodule

// File: hdl/prs_host.sv
// host end: receives page requests and markers, answers whole groups
// assumes groups from the function are not interleaved
`timescale 1ns/1ps
`include "prs_cfg.svh"
module prs_host
  import prs_pkg::*;
(
  input  wire logic                     mclk,
  input  wire logic                     reset,
  prs_link_if.host                      link,
  input  wire logic [`PRS_ADDR_W-1:0]   addr_limit,
  input  wire logic [`PRS_PASID_W-1:0]  pasid_max,
  input  wire logic                     halt,
  output logic                          marker_seen,
  output logic      [`PRS_PASID_W-1:0]  marker_pasid,
  output logic                          dead
);
  typedef struct packed {
    logic                     dead;
    logic                     acc_fail;
    logic                     r_vld;
    prs_rsp_s                 r;
    logic                     mk_seen;
    logic [`PRS_PASID_W-1:0]  mk_pasid;
  } prs_host_s;

  prs_host_s  s;
  prs_host_s  next_s;
  logic       take;
  logic       is_marker;
  logic       bad;
  logic       fail;

  always_comb
  begin
    next_s         = s;
    next_s.r_vld   = 1'b0;
    next_s.mk_seen = 1'b0;
    take      = link.msg_valid && !s.r_vld;
    is_marker = link.msg.prefix && link.msg.last
                && !link.msg.rd && !link.msg.wr;
    // (R11) bad address or no access requested
    bad = (!link.msg.rd && !link.msg.wr)
          || (link.msg.addr >= addr_limit);
    // (R12) prefix disabled, bad ID, execute without read
    if (link.msg.prefix)
      bad = bad || !link.prefix_en || (link.msg.pasid > pasid_max)
            || (link.msg.exe && !link.msg.rd);
    fail = s.acc_fail || bad;

    if (take)
    begin
      if (is_marker)
      begin
        // (R3) (R4) marker closes the old use, no answer, no credit
        next_s.mk_seen  = 1'b1;
        next_s.mk_pasid = link.msg.pasid;
      end
      else if (link.msg.last)
      begin
        next_s.acc_fail = 1'b0;
        if (!s.dead)
        begin
          next_s.r_vld   = 1'b1;
          next_s.r.index = link.msg.index;
          // (R14) (R15) prefix when expected and requested, even while prefix_en is clear
          next_s.r.prefix = link.rsp_pasid_req && link.msg.prefix;
          // (R16) ID copied from the request
          next_s.r.pasid  = next_s.r.prefix ? link.msg.pasid : '0;
          if (halt)
            next_s.r.code = `PRS_RSP_FAILURE;
          else if (fail)
            next_s.r.code = `PRS_RSP_INVALID;
          else
            next_s.r.code = `PRS_RSP_SUCCESS;
          // (R13) unspecified failure stops all further answers
          if (halt)
            next_s.dead = 1'b1;
        end
      end
      else
        next_s.acc_fail = fail;
    end

    if (link.pri_reset)
    begin
      next_s.dead     = 1'b0;
      next_s.acc_fail = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      s <= '0;
    else
      s <= next_s;
  end

  // one response slot: new messages wait while it is occupied
  assign link.msg_ready = !s.r_vld;
  assign link.rsp_valid = s.r_vld;
  assign link.rsp       = s.r;
  assign marker_seen    = s.mk_seen;
  assign marker_pasid   = s.mk_pasid;
  assign dead           = s.dead;
endmodule

// File: verification/prs_link_chk.sv
// checker of one link: marker format, message hold, response pairing
// assumes all signals are sampled on the one link clock
`timescale 1ns/1ps
module prs_link_chk
  import prs_pkg::*;
(
  input wire logic     mclk,
  input wire logic     reset,
  input wire logic     msg_valid,
  input wire logic     msg_ready,
  input wire prs_msg_s msg,
  input wire logic     rsp_valid,
  input wire prs_rsp_s rsp,
  input wire logic     rsp_pasid_req,
  input wire logic     prefix_en,
  input wire logic     pri_reset
);
  logic mk;
  logic hs;

  assign mk = msg_valid && msg.last && !msg.rd && !msg.wr;
  assign hs = msg_valid && msg_ready;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // ==========================================================
  // stop marker encoding
  marker_prefix_a: assert property (mk |-> msg.prefix)
    else $error("marker without prefix");
  marker_type_a: assert property (mk |-> msg.mtype == 5'h00)
    else $error("marker type not zero");
  marker_class_a: assert property (mk |-> msg.tc == 3'h0 && !msg.ro)
    else $error("marker class or ordering wrong");
  marker_rsvd_a: assert property (mk |-> !msg.exe && !msg.priv)
    else $error("marker request bits set");

  // ==========================================================
  // ordering and responses
  msg_hold_a: assert property (msg_valid && !msg_ready |=>
    msg_valid && $stable(msg))
    else $error("message dropped or changed while stalled");
  marker_norsp_a: assert property (hs && mk |=> !rsp_valid)
    else $error("marker answered");
  rsp_next_a: assert property (hs && msg.last && !mk |=> rsp_valid)
    else $error("group not answered");
  rsp_match_a: assert property (rsp_valid |->
    $past(hs) && rsp.index == $past(msg.index) &&
    rsp.prefix == $past(msg.prefix) &&
    (!rsp.prefix || rsp.pasid == $past(msg.pasid)))
    else $error("response does not match request");
  rsp_prefix_a: assert property (rsp_valid && rsp.prefix |->
    rsp_pasid_req)
    else $error("response prefix while not expected");
  pri_flush_a: assert property (pri_reset |=> !msg_valid)
    else $error("message kept across interface reset");

  cover property (hs && mk);
  cover property (rsp_valid && rsp.prefix);
  cover property (msg_valid && !msg_ready);
endmodule

// File: verification/testbench.sv
// testbench: function and host ends joined by one link
// assumes 100 MHz clock and synchronous active high reset
`timescale 1ns/1ps
`include "prs_cfg.svh"
module testbench
  import prs_pkg::*;
;
  logic                    mclk = 1'b0;
  logic                    reset = 1'b1;
  logic [7:0]              reg_addr = 8'h00;
  logic [31:0]             reg_wdata = 32'h0;
  logic                    reg_we = 1'b0;
  logic                    reg_re = 1'b0;
  logic [31:0]             reg_rdata;
  logic                    req_valid = 1'b0;
  logic                    req_ready;
  prs_msg_s                rq = '0;
  prs_msg_s                m;
  logic                    stop_valid = 1'b0;
  logic                    stop_ready;
  logic [`PRS_PASID_W-1:0] stop_pasid = 20'h0;
  logic                    stop_done;
  logic                    rsp_valid;
  prs_rsp_s                rsp;
  prs_rsp_s                got;
  logic [`PRS_ADDR_W-1:0]  addr_limit = 52'h1000;
  logic [`PRS_PASID_W-1:0] pasid_max = 20'h100;
  logic                    halt = 1'b0;
  logic                    marker_seen;
  logic [`PRS_PASID_W-1:0] marker_pasid;
  logic                    dead;
  int                      n_fail = 0;
  int                      n_tests = 0;
  int                      cyc = 0;
  int                      n_rsp = 0;
  int                      n_msg = 0;
  int                      n_done = 0;
  int                      n_mark = 0;
  int                      b;

  always #5 mclk = ~mclk;

  prs_link_if prs_link_if_i ();
  prs_device prs_device_i (.mclk(mclk), .reset(reset),
    .link(prs_link_if_i), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .req_valid(req_valid), .req_ready(req_ready), .req_prefix(rq.prefix),
    .req_pasid(rq.pasid), .req_exe(rq.exe), .req_priv(rq.priv),
    .req_rd(rq.rd), .req_wr(rq.wr), .req_last(rq.last),
    .req_index(rq.index), .req_addr(rq.addr), .stop_valid(stop_valid),
    .stop_ready(stop_ready), .stop_pasid(stop_pasid),
    .stop_done(stop_done), .rsp_valid(rsp_valid), .rsp(rsp));
  prs_host prs_host_i (.mclk(mclk), .reset(reset), .link(prs_link_if_i),
    .addr_limit(addr_limit), .pasid_max(pasid_max), .halt(halt),
    .marker_seen(marker_seen), .marker_pasid(marker_pasid), .dead(dead));
  prs_link_chk prs_link_chk_i (.mclk(mclk), .reset(reset),
    .msg_valid(prs_link_if_i.msg_valid),
    .msg_ready(prs_link_if_i.msg_ready), .msg(prs_link_if_i.msg),
    .rsp_valid(prs_link_if_i.rsp_valid), .rsp(prs_link_if_i.rsp),
    .rsp_pasid_req(prs_link_if_i.rsp_pasid_req),
    .prefix_en(prs_link_if_i.prefix_en),
    .pri_reset(prs_link_if_i.pri_reset));

  // ==========================================================
  // monitors, sampled mid-cycle where everything has settled
  always @(negedge mclk)
  begin
    n_rsp += int'(rsp_valid === 1'b1);
    n_done += int'(stop_done === 1'b1);
    n_mark += int'(marker_seen === 1'b1);
    n_msg += int'(prs_link_if_i.msg_valid && prs_link_if_i.msg_ready);
    if (rsp_valid === 1'b1)
      got = rsp;
  end

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_fail++;
      end_of_test();
    end
  end

  // ==========================================================
  // tasks
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_re <= 1'b0;
    #1 check(reg_rdata, e);
  endtask

  function automatic prs_msg_s pr(input logic [19:0] p, input logic x,
    input logic r, input logic l, input logic [8:0] i);
    return '{prefix:1'b1, pasid:p, exe:x, rd:r, wr:1'b1, last:l,
             index:i, addr:52'h10, default:'0};
  endfunction

  task automatic req(input prs_msg_s m);
    @(posedge mclk);
    rq <= m;
    req_valid <= 1'b1;
    do @(negedge mclk); while (req_ready !== 1'b1);
    @(posedge mclk);
    req_valid <= 1'b0;
  endtask

  // bounded wait until a monitor count reaches its target
  task automatic upto(ref int c, input int t);
    for (int w = 0; w < 30 && c < t; w++)
      @(negedge mclk);
  endtask

  task automatic end_of_test();
    $display("tests=%0d failures=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================
  // sequence
  initial
  begin
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    rd(`PRS_OFS_CAP, 32'h20);
    wr(`PRS_OFS_CAP, 32'hFF);
    rd(`PRS_OFS_CAP, 32'h20);
    rd(`PRS_OFS_STATUS, 32'h8000);
    rd(`PRS_OFS_CTRL, 32'h0);
    wr(`PRS_OFS_CTRL, 32'h801F);
    rd(`PRS_OFS_CTRL, 32'h801F);
    wr(`PRS_OFS_CFG, 32'h3);
    rd(`PRS_OFS_CFG, 32'h0);
    wr(`PRS_OFS_CTRL, 32'h0);
    wr(`PRS_OFS_CFG, 32'h1);
    rd(`PRS_OFS_CFG, 32'h1);
    rd(8'h40, 32'h0);
    wr(`PRS_OFS_ALLOC, 32'h4);
    rd(`PRS_OFS_ALLOC, 32'h4);
    // good, bad ID, execute without read, address at limit
    for (int k = 0; k < 4; k++)
    begin
      b = n_rsp;
      m = pr(k == 1 ? 20'h101 : 20'h5, k == 2, k != 2, 1'b1, 9'(k));
      m.addr = (k == 3) ? addr_limit : 52'h10;
      req(m);
      upto(n_rsp, b + 1);
      check(32'(got.code), k == 0 ? 32'h0 : 32'h1);
      check(32'(got.index), 32'(k));
    end
    // two groups back to back, answers in order
    b = n_rsp;
    req(pr(20'h5, 1'b0, 1'b1, 1'b1, 9'h0A));
    req(pr(20'h5, 1'b0, 1'b1, 1'b1, 9'h0B));
    upto(n_rsp, b + 2);
    check(32'(n_rsp - b), 32'h2);
    check(32'(got.index), 32'h0B);
    // terminal failure until interface reset
    @(posedge mclk) halt <= 1'b1;
    b = n_rsp;
    req(pr(20'h5, 1'b0, 1'b1, 1'b1, 9'h0C));
    upto(n_rsp, b + 1);
    check(32'(got.code), 32'hF);
    check(32'(dead), 32'h1);
    @(posedge mclk) halt <= 1'b0;
    wr(`PRS_OFS_CFG, 32'h5);
    b = n_rsp;
    req(pr(20'h5, 1'b0, 1'b1, 1'b1, 9'h0D));
    upto(n_rsp, b + 1);
    check(32'(got.code), 32'h0);
    // stop with a group left open
    b = n_msg;
    req(pr(20'h7, 1'b0, 1'b1, 1'b0, 9'h07));
    @(posedge mclk);
    stop_pasid <= 20'h7;
    stop_valid <= 1'b1;
    do @(negedge mclk); while (stop_ready !== 1'b1);
    @(posedge mclk);
    stop_valid <= 1'b0;
    rq <= pr(20'h7, 1'b0, 1'b1, 1'b1, 9'h09);
    req_valid <= 1'b1;
    repeat (3) @(negedge mclk);
    check(32'(req_ready), 32'h0);
    @(posedge mclk);
    req_valid <= 1'b0;
    req(pr(20'h7, 1'b0, 1'b1, 1'b1, 9'h07));
    upto(n_done, 1);
    check(32'(n_done), 32'h1);
    check(32'(n_msg - b), 32'h3);
    check(32'(marker_pasid), 32'h7);
    check(32'(n_mark), 32'h1);
    upto(n_rsp, n_rsp + 3);
    rd(`PRS_OFS_CFG, 32'h1);
    end_of_test();
  end
endmodule
